// file: hdl/eec_params.svh
// constants of the serial eeprom command controller: offsets, fields, reset values, timing
// assumes inclusion by bare name from the controller and from the testbench
`ifndef EEC_PARAMS_SVH
`define EEC_PARAMS_SVH
// ==========================================
// register map (byte addresses on apb)
`define EEC_ADDR_W 12
`define EEC_CMD_OFFSET 12'h0B0
`define EEC_DATA_OFFSET 12'h0B4
// ==========================================
// command register fields
`define EEC_BUSY_BIT 31
`define EEC_OP_HI 30
`define EEC_OP_LO 28
`define EEC_TMO_BIT 9
`define EEC_LOADED_BIT 8
`define EEC_LOC_HI 7
`define EEC_LOC_LO 0
`define EEC_CMD_GAP_W 18
// ==========================================
// data register and reset values
`define EEC_BYTE_HI 7
`define EEC_BYTE_LO 0
`define EEC_RSVD_W 24
`define EEC_BYTE_RESET 8'h00
`define EEC_LOC_RESET 8'h00
`define EEC_MAC_RESET 48'h0000_0000_0000
// ==========================================
// station address reload
`define EEC_MARKER_DEFAULT 8'h5A
`define EEC_MARKER_LOC 8'h00
`define EEC_RLD_MARK_IDX 3'h0
`define EEC_RLD_LAST_IDX 3'h6
`define EEC_RLD_STEP 3'h1
`define EEC_BYTE_BITS 8
// ==========================================
// timing
`define EEC_CLK_HZ 10000000
`define EEC_MS_PER_S 1000
`define EEC_TIMEOUT_MS 30
`endif

// file: hdl/eec_pkg.sv
// types of the serial eeprom command controller
// assumes eec_params.svh on the include path
package eec_pkg;
    // ==========================================
    // command codes as held in the command register
    typedef enum logic [2:0]
    {
        EEC_OP_READ = 3'h0,
        EEC_OP_LOCK = 3'h1,
        EEC_OP_UNLOCK = 3'h2,
        EEC_OP_WRITE = 3'h3,
        EEC_OP_WRITE_ALL = 3'h4,
        EEC_OP_ERASE = 3'h5,
        EEC_OP_ERASE_ALL = 3'h6,
        EEC_OP_RELOAD = 3'h7
    } eec_op_e;
    // ==========================================
    // controller states, one-hot
    typedef enum logic [2:0]
    {
        EEC_S_IDLE = 3'h1,
        EEC_S_WAIT = 3'h2,
        EEC_S_GAP = 3'h4
    } eec_state_e;
endpackage

// file: hdl/eec_timer.sv
// no-response watchdog for one eeprom operation
// assumes run_in stays high for the whole wait and drops between operations
module eec_timer #(
    parameter int unsigned LIMIT = 300000
)
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic run_in,
    output logic expired_out
);
    logic [31:0] count;
    wire logic at_limit;

    // ==========================================
    // counter
    // restarts whenever run drops, so each operation gets the full window
    assign at_limit = run_in && (count == LIMIT - 32'h1);

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            count <= '0;
            expired_out <= 1'b0;
        end
        else
        begin
            count <= (run_in && !at_limit) ? count + 32'h1 : '0;
            expired_out <= at_limit;
        end
    end
endmodule

// file: hdl/eec_ctrl.sv
// serial eeprom command controller: apb register slave plus command sequencer
// assumes a request/done eeprom engine outside, and a single 10 MHz clock
`include "eec_params.svh"

// Notes on behaviour
// R1 - after the lock command, erase and write commands are ignored until unlocked
// R2 - after the unlock command, erase and write stay allowed until locked or reset
// R3 - after reset the erase/write path starts locked
// R4 - erase or write while locked fails; software must unlock first
// R5 - unlocked single write stores the data register byte
// R6 - single write targets the location field of the command register
// R7 - unlocked write-all copies the data register byte into every location
// R8 - unlocked single erase erases only the selected location
// R9 - reload reads station address; marker at location zero required, else nothing loaded
// R10 - unlocked erase-all starts one bulk erase of the whole array
// R11 - no answer in 30 ms: abandon, go idle, set sticky timeout flag
// R12 - sticky loaded flag sets after a successful load at reset or reload
// R13 - data register low byte holds eeprom data; upper bits reserved, read zero
module eec_ctrl #(
    parameter int unsigned TIMEOUT_CYCLES = `EEC_TIMEOUT_MS * (`EEC_CLK_HZ / `EEC_MS_PER_S),
    parameter logic [7:0] MARKER = `EEC_MARKER_DEFAULT
)
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [`EEC_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic eep_req_out,
    output logic [2:0] eep_op_out,
    output logic [7:0] eep_addr_out,
    output logic [7:0] eep_wdata_out,
    input wire logic eep_done_in,
    input wire logic [7:0] eep_rdata_in,
    output logic [47:0] mac_addr_out,
    output logic mac_loaded_out
);
    eec_pkg::eec_state_e state;
    eec_pkg::eec_state_e next_state;
    eec_pkg::eec_op_e cmd_op;
    logic [7:0] cmd_loc;
    logic [7:0] data_byte;
    logic [2:0] rld_idx;
    logic unlocked;
    logic tmo_flag;
    logic boot_pending;
    logic tmo_exp;

    // ==========================================
    // helpers
    function automatic logic is_modify(input logic [2:0] op);
        is_modify = (op == eec_pkg::EEC_OP_WRITE) || (op == eec_pkg::EEC_OP_WRITE_ALL) ||
                    (op == eec_pkg::EEC_OP_ERASE) || (op == eec_pkg::EEC_OP_ERASE_ALL);
    endfunction

    function automatic int unsigned mac_pos(input logic [2:0] idx);
        mac_pos = (int'(idx) - int'(`EEC_RLD_STEP)) * `EEC_BYTE_BITS;
    endfunction

    // ==========================================
    // apb decode
    wire logic access_ph = psel_in && penable_in;
    wire logic hit_cmd = (paddr_in == `EEC_CMD_OFFSET);
    wire logic hit_data = (paddr_in == `EEC_DATA_OFFSET);
    wire logic hit_any = hit_cmd || hit_data;
    wire logic commit = access_ph && pready_out;
    wire logic wr_commit = commit && pwrite_in && hit_any;
    wire logic is_idle = (state == eec_pkg::EEC_S_IDLE);
    wire logic busy_view = !is_idle || boot_pending;
    wire logic [2:0] wr_op = pwdata_in[`EEC_OP_HI:`EEC_OP_LO];
    wire logic [7:0] wr_loc = pwdata_in[`EEC_LOC_HI:`EEC_LOC_LO];
    // a command write while busy is dropped except for its flag-clear bits; software polls the busy bit first
    wire logic cmd_wr_ok = wr_commit && hit_cmd && !busy_view;
    wire logic start_cmd = cmd_wr_ok && pwdata_in[`EEC_BUSY_BIT];
    wire logic [31:0] cmd_view = {busy_view, cmd_op, {`EEC_CMD_GAP_W{1'b0}}, tmo_flag, mac_loaded_out, cmd_loc};
    wire logic [31:0] data_view = {{`EEC_RSVD_W{1'b0}}, data_byte}; // R13
    wire logic [31:0] next_prdata = hit_cmd ? cmd_view : (hit_data ? data_view : '0);

    // ==========================================
    // launch decision
    wire logic launch_req = is_idle && (boot_pending || start_cmd);
    wire logic [2:0] launch_op = boot_pending ? eec_pkg::EEC_OP_RELOAD : wr_op;
    wire logic locked_drop = launch_req && is_modify(launch_op) && !unlocked; // R1 R4
    wire logic launch = launch_req && !locked_drop;
    wire logic launch_rld = launch_op == eec_pkg::EEC_OP_RELOAD;
    wire logic [2:0] next_eep_op = launch_rld ? eec_pkg::EEC_OP_READ : launch_op;
    wire logic [7:0] next_eep_addr = (launch_rld || boot_pending) ? `EEC_MARKER_LOC : wr_loc; // R6 R8

    // ==========================================
    // completion decode
    wire logic waiting = (state == eec_pkg::EEC_S_WAIT);
    wire logic done = waiting && eep_done_in;
    // an answer in the same cycle as the watchdog fires still counts
    wire logic tmo_hit = waiting && tmo_exp && !eep_done_in; // R11
    wire logic cur_rld = (cmd_op == eec_pkg::EEC_OP_RELOAD);
    wire logic at_mark = (rld_idx == `EEC_RLD_MARK_IDX);
    wire logic at_last = (rld_idx == `EEC_RLD_LAST_IDX);
    wire logic mark_ok = at_mark && (eep_rdata_in == MARKER); // R9
    wire logic rld_cont = cur_rld && (mark_ok || (!at_mark && !at_last));
    wire logic rld_store = done && cur_rld && !at_mark;
    wire logic rld_finish = rld_store && at_last; // R12
    wire logic in_gap = (state == eec_pkg::EEC_S_GAP);

    assign next_state = launch ? eec_pkg::EEC_S_WAIT :
                        in_gap ? eec_pkg::EEC_S_WAIT :
                        tmo_hit ? eec_pkg::EEC_S_IDLE :
                        (done && rld_cont) ? eec_pkg::EEC_S_GAP :
                        done ? eec_pkg::EEC_S_IDLE : state;

    // ==========================================
    // watchdog
    eec_timer #(
        .LIMIT(TIMEOUT_CYCLES)
    )
    u_eec_timer (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .run_in(waiting && !eep_done_in),
        .expired_out(tmo_exp)
    );

    // ==========================================
    // apb answer: one wait state so read data comes from a flop
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= '0;
        end
        else
        begin
            pready_out <= access_ph && !pready_out;
            pslverr_out <= access_ph && !pready_out && !hit_any;
            prdata_out <= next_prdata;
        end
    end

    // ==========================================
    // sequencer state and command fields
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state <= eec_pkg::EEC_S_IDLE;
            cmd_op <= eec_pkg::EEC_OP_READ;
            cmd_loc <= `EEC_LOC_RESET;
            boot_pending <= 1'b1;
        end
        else
        begin
            state <= next_state;
            if (launch_req)
                boot_pending <= 1'b0;
            if (launch_req)
                cmd_op <= eec_pkg::eec_op_e'(launch_op);
            else if (cmd_wr_ok)
                cmd_op <= eec_pkg::eec_op_e'(wr_op);
            if (cmd_wr_ok)
                cmd_loc <= wr_loc;
        end
    end

    // ==========================================
    // unlock state; reset leaves it locked
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            unlocked <= 1'b0; // R3
        else if (done && cmd_op == eec_pkg::EEC_OP_UNLOCK)
            unlocked <= 1'b1; // R2
        else if (done && cmd_op == eec_pkg::EEC_OP_LOCK)
            unlocked <= 1'b0; // R1
    end

    // ==========================================
    // sticky flags: hardware set wins over a same-cycle clear
    wire logic clr_tmo = wr_commit && hit_cmd && pwdata_in[`EEC_TMO_BIT];
    wire logic clr_loaded = wr_commit && hit_cmd && pwdata_in[`EEC_LOADED_BIT];

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tmo_flag <= 1'b0;
            mac_loaded_out <= 1'b0;
        end
        else
        begin
            tmo_flag <= tmo_hit || (tmo_flag && !clr_tmo); // R11
            mac_loaded_out <= rld_finish || (mac_loaded_out && !clr_loaded); // R12
        end
    end

    // ==========================================
    // data register: eeprom read result wins over a host write
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            data_byte <= `EEC_BYTE_RESET;
        else if (done && cmd_op == eec_pkg::EEC_OP_READ)
            data_byte <= eep_rdata_in;
        else if (wr_commit && hit_data && !busy_view)
            data_byte <= pwdata_in[`EEC_BYTE_HI:`EEC_BYTE_LO]; // R13
    end

    // ==========================================
    // station address reload
    // the address is written piecewise, so it is only trusted once the loaded flag rises
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rld_idx <= `EEC_RLD_MARK_IDX;
            mac_addr_out <= `EEC_MAC_RESET;
        end
        else
        begin
            if (launch)
                rld_idx <= `EEC_RLD_MARK_IDX;
            else if (done && rld_cont)
                rld_idx <= rld_idx + `EEC_RLD_STEP; // R9
            if (rld_store)
                mac_addr_out[mac_pos(rld_idx) +: `EEC_BYTE_BITS] <= eep_rdata_in;
        end
    end

    // ==========================================
    // eeprom request port
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            eep_req_out <= 1'b0;
            eep_op_out <= eec_pkg::EEC_OP_READ;
            eep_addr_out <= `EEC_LOC_RESET;
            eep_wdata_out <= `EEC_BYTE_RESET;
        end
        else if (launch)
        begin
            eep_req_out <= 1'b1; // R7 R10
            eep_op_out <= next_eep_op;
            eep_addr_out <= next_eep_addr; // R6
            eep_wdata_out <= data_byte; // R5 R7
        end
        else if (in_gap)
        begin
            eep_req_out <= 1'b1;
            eep_addr_out <= {5'h00, rld_idx};
        end
        else if (done || tmo_hit)
            eep_req_out <= 1'b0; // R11
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence rld_mark_bad_s;
        waiting && cur_rld && at_mark && eep_done_in && (eep_rdata_in != MARKER);
    endsequence

    sequence rld_last_byte_s;
        waiting && cur_rld && at_last && eep_done_in;
    endsequence

    locked_drop_a: assert property (locked_drop |=> is_idle && !eep_req_out [*2]) // R1 R4
        else $error("modify command ran while locked");
    unlock_rise_a: assert property ($rose(unlocked) |-> $past(done) && $past(cmd_op) == eec_pkg::EEC_OP_UNLOCK) // R2 R3
        else $error("unlock set without unlock command");
    lock_cmd_a: assert property (done && cmd_op == eec_pkg::EEC_OP_LOCK |=> !unlocked) // R1
        else $error("lock command left path unlocked");
    write_issue_a: assert property (launch && launch_op == eec_pkg::EEC_OP_WRITE |=>
        eep_req_out && eep_op_out == eec_pkg::EEC_OP_WRITE && eep_wdata_out == $past(data_byte)
        && eep_addr_out == $past(wr_loc)) // R5 R6
        else $error("single write issued wrongly");
    write_all_a: assert property (launch && launch_op == eec_pkg::EEC_OP_WRITE_ALL |=>
        eep_req_out && eep_op_out == eec_pkg::EEC_OP_WRITE_ALL && eep_wdata_out == $past(data_byte)) // R7
        else $error("write all issued wrongly");
    erase_loc_a: assert property (launch && launch_op == eec_pkg::EEC_OP_ERASE |=>
        eep_op_out == eec_pkg::EEC_OP_ERASE && eep_addr_out == $past(wr_loc)) // R8
        else $error("erase hit wrong location");
    erase_all_a: assert property (launch && launch_op == eec_pkg::EEC_OP_ERASE_ALL |=>
        eep_req_out && eep_op_out == eec_pkg::EEC_OP_ERASE_ALL ##1 eep_req_out || !waiting) // R10
        else $error("erase all not issued");
    marker_fail_a: assert property (rld_mark_bad_s |=> is_idle && $stable(mac_addr_out)
        && mac_loaded_out == $past(mac_loaded_out && !clr_loaded)) // R9
        else $error("reload went on without marker");
    reload_done_a: assert property (rld_last_byte_s |=> mac_loaded_out && is_idle) // R12
        else $error("loaded flag missing after reload");
    timeout_a: assert property (tmo_hit |=> is_idle && tmo_flag && !eep_req_out) // R11
        else $error("timeout not handled");
    data_rsvd_a: assert property (pready_out && hit_data && !pwrite_in |-> prdata_out[31:8] == '0) // R13
        else $error("reserved data bits not zero");
endmodule

// file: testbench/eec_eeprom_model.sv
// behavioural serial eeprom behind the request/done engine port of the controller
// assumes req_in is held until done_out and dropped one cycle after it
module eec_eeprom_model #(
    parameter logic [7:0] MARKER = 8'h5A
)
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic req_in,
    input wire logic [2:0] op_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] delay_in,
    input wire logic mute_in,
    output logic done_out,
    output logic [7:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:255];
    logic [7:0] cnt;
    logic served;
    logic unlocked;
    // ==========================================
    // contents survive reset, as a real array does
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'h10 + 8'(i);
        mem[0] = MARKER;
    end
    // ==========================================
    // answer engine; mute_in models a missing device
    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cnt <= 8'h00;
            done_out <= 1'b0;
            served <= 1'b0;
            unlocked <= 1'b0;
            rdata_out <= 8'h00;
        end
        else
        begin
            done_out <= 1'b0;
            rdata_out <= ~rdata_out; // outside done the last byte is inverted every cycle, so it is never held steady
            if (!req_in)
            begin
                served <= 1'b0;
                cnt <= 8'h00;
            end
            else if (!served && !mute_in)
            begin
                if (cnt < delay_in)
                    cnt <= cnt + 8'h01;
                else
                begin
                    done_out <= 1'b1;
                    served <= 1'b1;
                    rdata_out <= mem[addr_in];
                    case (op_in)
                        3'h1: unlocked <= 1'b0;
                        3'h2: unlocked <= 1'b1;
                        3'h3: if (unlocked) mem[addr_in] <= wdata_in;
                        3'h4: if (unlocked) for (int k = 0; k < 256; k++) mem[k] <= wdata_in;
                        3'h5: if (unlocked) mem[addr_in] <= 8'hFF;
                        3'h6: if (unlocked) for (int k = 0; k < 256; k++) mem[k] <= 8'hFF;
                        default: ;
                    endcase
                end
            end
        end
    end
endmodule

// file: testbench/tb_serial_eeprom_command_ops.sv
// self-checking bench for the eeprom command controller over apb
// assumes the behavioural eeprom model on the engine port, short watchdog limit
`include "eec_params.svh"
module tb_serial_eeprom_command_ops;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0000_0000;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, eep_req_out, eep_done_in, mac_loaded_out;
    logic [2:0] eep_op_out;
    logic [7:0] eep_addr_out, eep_wdata_out, eep_rdata_in;
    logic [47:0] mac_addr_out;
    logic [7:0] delay = 8'h00;
    logic mute = 1'b0;
    int fail_count = 0;
    int comparisons = 0;
    localparam logic [11:0] CMD = `EEC_CMD_OFFSET;
    localparam logic [11:0] DAT = `EEC_DATA_OFFSET;
    always #50 clk_in = ~clk_in;
    eec_ctrl #(.TIMEOUT_CYCLES(20), .MARKER(8'h5A)) u_eec_ctrl (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .eep_req_out(eep_req_out), .eep_op_out(eep_op_out), .eep_addr_out(eep_addr_out),
        .eep_wdata_out(eep_wdata_out), .eep_done_in(eep_done_in), .eep_rdata_in(eep_rdata_in),
        .mac_addr_out(mac_addr_out), .mac_loaded_out(mac_loaded_out));
    eec_eeprom_model #(.MARKER(8'h5A)) u_eec_eeprom_model (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .req_in(eep_req_out), .op_in(eep_op_out), .addr_in(eep_addr_out), .wdata_in(eep_wdata_out),
        .delay_in(delay), .mute_in(mute), .done_out(eep_done_in), .rdata_out(eep_rdata_in));
    // ==========================================
    // shared tasks
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [47:0] act, input logic [47:0] exp);
        comparisons++;
        if (act !== exp)
        begin
            $display("ERROR at %0t: got %h expected %h", $time, act, exp);
            fail_count++;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 50);
        if (n >= 50)
            check({47'h0, pready_out}, 48'h1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_bit(input int b, input logic exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, CMD, 32'h0, r, e);
        check({47'h0, r[b]}, {47'h0, exp});
    endtask
    task automatic cmd(input eec_pkg::eec_op_e op, input logic [7:0] loc);
        logic [31:0] r;
        logic e;
        int n;
        wr(CMD, {1'b1, op, 20'h00000, loc});
        n = 0;
        do
        begin
            apb(1'b0, CMD, 32'h0, r, e);
            n++;
        end
        while (r[31] !== 1'b0 && n < 100);
        if (n >= 100)
            check({47'h0, r[31]}, 48'h0);
    endtask
    function automatic logic [47:0] mem(input logic [7:0] a);
        return {40'h0, u_eec_eeprom_model.mem[a]};
    endfunction
    // ==========================================
    // scenarios
    task automatic test_powerup();
        logic [31:0] r;
        logic e;
        cmd(eec_pkg::EEC_OP_READ, 8'h00);
        check(mac_addr_out, 48'h1615_1413_1211);
        check({47'h0, mac_loaded_out}, 48'h1);
        apb(1'b0, DAT, 32'h0, r, e);
        check({16'h0, r}, 48'h0);
        apb(1'b0, 12'h0B8, 32'h0, r, e);
        check({47'h0, e}, 48'h1);
    endtask
    task automatic test_locked();
        wr(DAT, 32'h0000_00A5);
        cmd(eec_pkg::EEC_OP_WRITE, 8'h10);
        check(mem(8'h10), 48'h20);
        // the model refuses locked writes too, so also prove nothing was issued
        check({45'h0, eep_op_out}, {45'h0, eec_pkg::EEC_OP_READ});
        cmd(eec_pkg::EEC_OP_ERASE_ALL, 8'h00);
        check(mem(8'h11), 48'h21);
    endtask
    task automatic test_write_erase();
        logic [31:0] r;
        logic e;
        delay <= 8'h0C;
        cmd(eec_pkg::EEC_OP_UNLOCK, 8'h00);
        wr(DAT, 32'hFFFF_FFC3);
        apb(1'b0, DAT, 32'h0, r, e);
        check({16'h0, r}, 48'hC3);
        cmd(eec_pkg::EEC_OP_WRITE, 8'h10);
        check(mem(8'h10), 48'hC3);
        check(mem(8'h11), 48'h21);
        cmd(eec_pkg::EEC_OP_ERASE, 8'h10);
        check(mem(8'h10), 48'hFF);
        check(mem(8'h11), 48'h21);
        cmd(eec_pkg::EEC_OP_READ, 8'h11);
        apb(1'b0, DAT, 32'h0, r, e);
        check({16'h0, r}, 48'h21);
        delay <= 8'h00;
    endtask
    task automatic test_reload();
        wr(DAT, 32'h0000_0077);
        cmd(eec_pkg::EEC_OP_WRITE, 8'h01);
        wr(CMD, 32'h0000_0100);
        rd_bit(8, 1'b0);
        cmd(eec_pkg::EEC_OP_RELOAD, 8'h00);
        rd_bit(8, 1'b1);
        check(mac_addr_out, 48'h1615_1413_1277);
    endtask
    task automatic test_bulk();
        wr(DAT, 32'h0000_003C);
        cmd(eec_pkg::EEC_OP_WRITE_ALL, 8'h00);
        check(mem(8'h00), 48'h3C);
        check(mem(8'hFF), 48'h3C);
        wr(CMD, 32'h0000_0100);
        cmd(eec_pkg::EEC_OP_RELOAD, 8'h00);
        rd_bit(8, 1'b0);
        check(mac_addr_out, 48'h1615_1413_1277);
        cmd(eec_pkg::EEC_OP_ERASE_ALL, 8'h00);
        check(mem(8'h00), 48'hFF);
        check(mem(8'h80), 48'hFF);
        cmd(eec_pkg::EEC_OP_LOCK, 8'h00);
        wr(DAT, 32'h0000_0011);
        cmd(eec_pkg::EEC_OP_WRITE, 8'h05);
        check(mem(8'h05), 48'hFF);
        check({45'h0, eep_op_out}, {45'h0, eec_pkg::EEC_OP_LOCK});
    endtask
    task automatic test_timeout();
        mute <= 1'b1;
        cmd(eec_pkg::EEC_OP_READ, 8'h00);
        check({47'h0, eep_req_out}, 48'h0);
        rd_bit(9, 1'b1);
        mute <= 1'b0;
        wr(CMD, 32'h0000_0200);
        rd_bit(9, 1'b0);
    endtask
    // ==========================================
    // main sequence and watchdog
    initial
    begin
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        test_powerup();
        test_locked();
        test_write_erase();
        test_reload();
        test_bulk();
        test_timeout();
        complete_run();
    end
    initial
    begin
        #2000000;
        $display("ERROR at %0t: watchdog got %h expected %h", $time, 1'b1, 1'b0);
        fail_count++;
        complete_run();
    end
endmodule
